/* File: ssc_capture.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - Address sampled on rising edge picks one memory location.
// - Active-low lane selects act only with write strobe; lane owns byte+parity.
// - Write strobe is sampled only on edges with clock gate low.
// - Advance/load high with gate low steps the burst counter of a live burst.
// - Advance/load low loads the presented address as a new access.
// - All synchronous inputs, write data included, captured on hclk.
// - Edges count only while the clock gate is low.
// - Selected only with first select low, second high, third low.
// - Raised gate holds previous cycle state, no deselect.
// - Strap high or floating is interleaved, low linear; fixed in use.
// - Data pins released in write data phase and while deselected.
module ssc_capture #(
	parameter int ADDR_W = 18,
	parameter int MEM_AW = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic clock_gate_n,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second,
	input wire logic chip_sel_third_n,
	input wire logic write_strobe_n,
	input wire logic advance_or_load,
	input wire logic lane_a_write_sel_n,
	input wire logic lane_b_write_sel_n,
	input wire logic lane_c_write_sel_n,
	input wire logic lane_d_write_sel_n,
	input wire logic burst_addr_bit0,
	input wire logic burst_addr_bit1,
	input wire logic [ADDR_W-3:0] addr_upper,
	input wire logic output_enable_n,
	input wire logic burst_order_strap,
	input wire logic [ssc_pkg::SSC_LANES*ssc_pkg::SSC_BYTE_W-1:0] dq_in,
	output logic [ssc_pkg::SSC_LANES*ssc_pkg::SSC_BYTE_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [ssc_pkg::SSC_LANES-1:0] parity_io_lane_in,
	output logic [ssc_pkg::SSC_LANES-1:0] parity_io_lane_out,
	output logic parity_io_lane_oe,
	output logic read_buf_ready
);
	import ssc_pkg::*;
	localparam int DEPTH = 1 << MEM_AW;
	typedef struct packed {
		logic ctrl_en;
		logic drain_stall;
		logic strap_s1;
		logic strap_s2;
		logic interleave;
		logic [2:0] strap_age;
		logic [ADDR_W-1:0] base;
		logic [SSC_BURST_W-1:0] cnt;
		logic live;
		logic last_wr;
		logic p1_v;
		logic p1_wr;
		logic [ADDR_W-1:0] p1_a;
		logic [SSC_LANES-1:0] p1_ln;
		logic p2_v;
		logic p2_wr;
		logic [ADDR_W-1:0] p2_a;
		logic [SSC_LANES-1:0] p2_ln;
		logic [DEPTH-1:0][SSC_WORD_W-1:0] mem;
		logic ap_v;
		logic ap_wr;
		logic [7:0] ap_a;
		logic [31:0] rdata;
	} ssc_state_type;
	ssc_state_type q;
	ssc_state_type next_q;
	logic en;
	logic sel;
	logic [SSC_LANES-1:0] lanes_n;
	logic [ADDR_W-1:0] pin_addr;
	logic [SSC_BURST_W-1:0] step_cnt;
	logic [SSC_BURST_W-1:0] step_low;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [SSC_WORD_W-1:0] buf_out_data;
	logic [1:0] buf_count;
	logic [31:0] stat_word;
	logic [MEM_AW-1:0] widx;
	logic [SSC_LANE_W-1:0] lane0_cur;
	// ****************************************
	// Pin decode
	// ****************************************
	// Gate low qualifies every edge; no edge, no change
	assign en = !clock_gate_n;
	assign sel = !chip_sel_first_n && chip_sel_second &&
		!chip_sel_third_n && q.ctrl_en;
	assign lanes_n = {lane_d_write_sel_n, lane_c_write_sel_n,
		lane_b_write_sel_n, lane_a_write_sel_n};
	assign pin_addr = {addr_upper, burst_addr_bit1, burst_addr_bit0};
	assign step_cnt = SSC_BURST_W'(q.cnt + 1'b1);
	// Only the two low bits move, so the burst stays aligned
	assign step_low = q.interleave ? (q.base[SSC_BURST_W-1:0] ^ step_cnt) :
		SSC_BURST_W'(q.base[SSC_BURST_W-1:0] + step_cnt);
	assign widx = q.p2_a[MEM_AW-1:0];
	assign lane0_cur = q.mem[widx][SSC_LANE_W-1:0];
	// ****************************************
	// Read data buffer
	// ****************************************
	// Read word leaves the array one edge after its command
	assign buf_in_valid = en && q.p1_v && !q.p1_wr;
	// Stall holds words; released, they drain so no later read sees them
	assign buf_out_ready = en && !q.drain_stall;
	assign read_buf_ready = buf_in_ready;
	ssc_skid_buf #(
		.WIDTH(SSC_WORD_W),
		.DEPTH(2)
	) u_rd_buf (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(q.mem[q.p1_a[MEM_AW-1:0]]),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data),
		.fill_count(buf_count)
	);

	// ****************************************
	// Pin drivers
	// ****************************************
	// Driven only in a read data phase; writes and deselect release
	assign dq_oe = buf_out_valid && q.p2_v && !q.p2_wr &&
		!output_enable_n;
	assign parity_io_lane_oe = dq_oe;
	always_comb begin
		for (int i = 0; i < SSC_LANES; i++) begin
			dq_out[i*SSC_BYTE_W +: SSC_BYTE_W] =
				buf_out_data[i*SSC_LANE_W +: SSC_BYTE_W];
			parity_io_lane_out[i] =
				buf_out_data[i*SSC_LANE_W + SSC_BYTE_W];
		end
	end

	// ****************************************
	// Bus slave answers
	// ****************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	always_comb begin
		stat_word = '0;
		stat_word[SSC_STAT_ILV_BIT] = q.interleave;
		stat_word[SSC_STAT_LIVE_BIT] = q.live;
		stat_word[SSC_STAT_LOW_LSB +: SSC_BURST_W] =
			q.p1_a[SSC_BURST_W-1:0];
		stat_word[SSC_STAT_CNT_LSB +: 2] = buf_count;
		stat_word[SSC_STAT_RDY_BIT] = buf_in_ready;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_q = q;
		// Strap passes two flops, then is caught once after release
		next_q.strap_s1 = burst_order_strap;
		next_q.strap_s2 = q.strap_s1;
		if (q.strap_age[1] && !q.strap_age[2]) begin
			next_q.interleave = q.strap_s2;
		end
		next_q.strap_age = {q.strap_age[1:0], 1'b1};
		// Register bus: word read is latched in the address phase
		next_q.ap_v = 1'b0;
		if (hsel && hready && htrans == SSC_HTRANS_NONSEQ) begin
			next_q.ap_v = 1'b1;
			next_q.ap_wr = hwrite;
			next_q.ap_a = haddr[7:0];
			next_q.rdata = '0;
			if (haddr[7:0] == SSC_CTRL_OFF) begin
				next_q.rdata[SSC_CTRL_EN_BIT] = q.ctrl_en;
				next_q.rdata[SSC_CTRL_STALL_BIT] = q.drain_stall;
			end else if (haddr[7:0] == SSC_STAT_OFF) begin
				next_q.rdata = stat_word;
			end
		end
		if (q.ap_v && q.ap_wr && q.ap_a == SSC_CTRL_OFF) begin
			next_q.ctrl_en = hwdata[SSC_CTRL_EN_BIT];
			next_q.drain_stall = hwdata[SSC_CTRL_STALL_BIT];
		end
		// Device pipeline moves only on qualified edges
		if (en) begin
			next_q.p2_v = q.p1_v;
			next_q.p2_wr = q.p1_wr;
			next_q.p2_a = q.p1_a;
			next_q.p2_ln = q.p1_ln;
			if (advance_or_load) begin
				next_q.p1_v = q.live;
				next_q.p1_wr = q.last_wr;
				next_q.p1_ln = ~lanes_n & {SSC_LANES{q.last_wr}};
				if (q.live) begin
					next_q.cnt = step_cnt;
					next_q.p1_a = {q.base[ADDR_W-1:SSC_BURST_W],
						step_low};
				end
			end else if (sel) begin
				next_q.base = pin_addr;
				next_q.cnt = '0;
				next_q.live = 1'b1;
				next_q.last_wr = !write_strobe_n;
				next_q.p1_v = 1'b1;
				next_q.p1_wr = !write_strobe_n;
				next_q.p1_a = pin_addr;
				next_q.p1_ln = ~lanes_n & {SSC_LANES{!write_strobe_n}};
			end else begin
				next_q.live = 1'b0;
				next_q.p1_v = 1'b0;
			end
			// Write data lands two edges after its address
			if (q.p2_v && q.p2_wr) begin
				for (int i = 0; i < SSC_LANES; i++) begin
					if (q.p2_ln[i]) begin
						next_q.mem[widx][i*SSC_LANE_W +: SSC_LANE_W] =
							{parity_io_lane_in[i],
							dq_in[i*SSC_BYTE_W +: SSC_BYTE_W]};
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ctrl_en <= SSC_CTRL_EN_RST;
			q.drain_stall <= SSC_CTRL_STALL_RST;
			q.interleave <= SSC_STRAP_RST;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_load;
		en && !advance_or_load && sel;
	endsequence
	sequence s_adv;
		en && advance_or_load && q.live;
	endsequence
	sequence s_lane0_off;
		en && q.p2_v && q.p2_wr && !q.p2_ln[0];
	endsequence
	AST_GATE_HOLD: assert property (!en |=> $stable(q.cnt) &&
		$stable(q.p1_v) && $stable(q.p2_v) && $stable(q.live))
		else $error("state moved on a gated edge");
	AST_LOAD: assert property (s_load |=> q.p1_v && q.cnt == '0 &&
		q.p1_a == $past(pin_addr))
		else $error("load did not take the pin address");
	AST_ADV: assert property (s_adv |=>
		q.cnt == SSC_BURST_W'($past(q.cnt) + 1'b1) && q.p1_v)
		else $error("advance did not step the counter");
	AST_WR_STROBE: assert property ((s_load and write_strobe_n) |=>
		!q.p1_wr && q.p1_ln == '0)
		else $error("write started with strobe high");
	AST_DESEL: assert property (en && !advance_or_load && !sel |=>
		!q.p1_v ##1 !q.p1_v || q.p2_v == 1'b0)
		else $error("command accepted while deselected");
	AST_OE_MASK: assert property (dq_oe |-> q.p2_v && !q.p2_wr &&
		!output_enable_n)
		else $error("data driven outside a read phase");
	AST_STRAP: assert property (q.strap_age[2] |=>
		$stable(q.interleave))
		else $error("burst order changed in use");
	AST_WRAP: assert property (q.p1_v && q.live |->
		q.p1_a[ADDR_W-1:SSC_BURST_W] == q.base[ADDR_W-1:SSC_BURST_W])
		else $error("burst left its aligned group");
	AST_LANE_KEEP: assert property (s_lane0_off |=>
		q.mem[$past(widx)][SSC_LANE_W-1:0] == $past(lane0_cur))
		else $error("masked lane was overwritten");
	AST_LANE_WRITE: assert property (en && q.p2_v && q.p2_ln[0] |=>
		q.mem[$past(widx)][SSC_LANE_W-1:0] ==
		$past({parity_io_lane_in[0], dq_in[SSC_BYTE_W-1:0]}))
		else $error("enabled lane not written");
endmodule : ssc_capture

/* File: ssc_pkg.sv */
package ssc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] SSC_CTRL_OFF = 8'h00;
	localparam logic [7:0] SSC_STAT_OFF = 8'h04;
	localparam int SSC_CTRL_EN_BIT = 0;
	localparam int SSC_CTRL_STALL_BIT = 1;
	localparam logic SSC_CTRL_EN_RST = 1'b1;
	localparam logic SSC_CTRL_STALL_RST = 1'b0;
	localparam int SSC_STAT_ILV_BIT = 0;
	localparam int SSC_STAT_LIVE_BIT = 1;
	localparam int SSC_STAT_LOW_LSB = 2;
	localparam int SSC_STAT_CNT_LSB = 4;
	localparam int SSC_STAT_RDY_BIT = 6;

	// ****************************************
	// Bus and data layout
	// ****************************************
	localparam logic [1:0] SSC_HTRANS_NONSEQ = 2'b10;
	localparam int SSC_LANES = 4;
	localparam int SSC_BYTE_W = 8;
	localparam int SSC_LANE_W = 9;
	localparam int SSC_WORD_W = 36;
	localparam int SSC_BURST_W = 2;
	localparam logic SSC_STRAP_RST = 1'b1;

endpackage : ssc_pkg

/* File: ssc_skid_buf.sv */
`timescale 1ns/10ps
module ssc_skid_buf #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] fill_count
);
	import ssc_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH) + 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} ssc_buf_type;

	ssc_buf_type q;
	ssc_buf_type next_q;
	logic push;
	logic pop;

	// ****************************************
	// Honest flags straight from the count
	// ****************************************
	assign in_ready = (q.count != CW'(DEPTH));
	assign out_valid = (q.count != '0);
	assign out_data = q.slot[q.rd_ptr];
	assign fill_count = q.count;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers wrap at DEPTH, so any depth works
	always_comb begin
		next_q = q;
		if (push) begin
			next_q.slot[q.wr_ptr] = in_data;
			next_q.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 :
				PW'(q.wr_ptr + 1'b1);
		end
		if (pop) begin
			next_q.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 :
				PW'(q.rd_ptr + 1'b1);
		end
		next_q.count = CW'(q.count + CW'(push) - CW'(pop));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

endmodule : ssc_skid_buf

/* File: ssc_ctrl_model.sv */
`timescale 1ns/10ps
// ****
// Memory controller stand-in
// ****
module ssc_ctrl_model (
	input wire logic hclk,
	output logic clock_gate_n,
	output logic [2:0] chip_sel,
	output logic write_strobe_n,
	output logic advance_or_load,
	output logic [3:0] lane_sel_n,
	output logic [17:0] addr,
	output logic [35:0] bus_to_dev,
	input wire logic [35:0] bus_from_dev,
	input wire logic dev_oe
);
	logic [35:0] wd, wd1, wd2;
	logic [35:0] last = 0;
	logic p1 = 0;
	logic p2 = 0;
	wire cmd_wr = !write_strobe_n && chip_sel == 3'h2;
	// Write data follows its command by two recognised edges
	always @(posedge hclk) begin
		if (!clock_gate_n) begin
			p1 <= cmd_wr;
			wd1 <= wd;
			p2 <= p1;
			wd2 <= wd1;
		end
	end
	// Released wire toggles, so stale data never passes for a match
	assign bus_to_dev = p2 ? wd2 : (dev_oe ? bus_from_dev : ~last);
	always @(posedge hclk) last <= bus_to_dev;
	// Idle and deselected at time zero
	initial begin
		clock_gate_n = 0;
		chip_sel = 3'h6;
		write_strobe_n = 1;
		advance_or_load = 0;
		lane_sel_n = 4'hf;
		addr = 0;
		wd = 0;
	end
	// One command per call, changed just after an edge
	task automatic cmd(input logic g, input logic [2:0] cs, input logic we,
		input logic adv, input logic [3:0] ln, input logic [17:0] a,
		input logic [35:0] d);
		@(posedge hclk);
		clock_gate_n <= g;
		chip_sel <= cs;
		write_strobe_n <= we;
		advance_or_load <= adv;
		lane_sel_n <= ln;
		addr <= a;
		wd <= d;
	endtask : cmd
endmodule : ssc_ctrl_model

/* File: sync_sram_command_capture_tb_top.sv */
`timescale 1ns/10ps
module sync_sram_command_capture_tb_top;
	import ssc_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, oen = 0, strap = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r, dq_out;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, dq_oe, par_oe, rbr, gn, we_n, adv;
	logic [2:0] cs;
	logic [3:0] ln, par_out;
	logic [17:0] a;
	logic [35:0] to_dev;
	logic [4:0] bad [5] = '{5'h14, 5'h0c, 5'h00, 5'h06, 5'h05};
	int bad_count = 0, checks = 0;
	// ****
	// Clock, run limit, design and partner
	// ****
	always #10 hclk = ~hclk;
	// Run limit of 20000 cycles, well beyond the expected run of under two hundred cycles
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
	ssc_capture DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.clock_gate_n(gn), .chip_sel_first_n(cs[2]), .chip_sel_second(cs[1]),
		.chip_sel_third_n(cs[0]), .write_strobe_n(we_n), .advance_or_load(adv),
		.lane_a_write_sel_n(ln[0]), .lane_b_write_sel_n(ln[1]),
		.lane_c_write_sel_n(ln[2]), .lane_d_write_sel_n(ln[3]),
		.burst_addr_bit0(a[0]), .burst_addr_bit1(a[1]), .addr_upper(a[17:2]),
		.output_enable_n(oen), .burst_order_strap(strap),
		.dq_in(to_dev[31:0]), .dq_out, .dq_oe,
		.parity_io_lane_in(to_dev[35:32]), .parity_io_lane_out(par_out),
		.parity_io_lane_oe(par_oe), .read_buf_ready(rbr));
	ssc_ctrl_model m (.hclk, .clock_gate_n(gn), .chip_sel(cs),
		.write_strobe_n(we_n), .advance_or_load(adv), .lane_sel_n(ln),
		.addr(a), .bus_to_dev(to_dev), .bus_from_dev({par_out, dq_out}),
		.dev_oe(dq_oe));
	// ****
	// Tasks
	// ****
	task automatic chk(input string n, input logic [35:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report();
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic rst(input logic s);
		strap <= s;
		hresetn <= 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		repeat (5) @(posedge hclk);
	endtask : rst
	// Single word transfer; read data lands in r
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= SSC_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h00_0000, ad};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic idle(input int n);
		repeat (n) m.cmd(0, 3'h6, 1, 0, 4'hf, 0, 0);
	endtask : idle
	task automatic rd(input logic [17:0] ad, input logic [35:0] e);
		m.cmd(0, 3'h2, 1, 0, 4'hf, ad, 0);
		idle(2);
		@(negedge hclk);
		chk("dq_oe", !oen, dq_oe);
		chk("par_oe", !oen, par_oe);
		if (!oen) chk("rdata", e, {par_out, dq_out});
	endtask : rd
	task automatic wr(input logic [17:0] ad, input logic [3:0] l,
		input logic [35:0] d);
		m.cmd(0, 3'h2, 0, 0, l, ad, d);
		idle(2);
		@(negedge hclk);
		chk("oe_in_write", 0, dq_oe);
		idle(1);
	endtask : wr
	// Load then three advances, each beat read back singly
	task automatic burst(input logic [17:0] b, input logic lin);
		for (int i = 0; i < 4; i++)
			m.cmd(0, 3'h2, 0, i != 0, 4'h0, i ? 18'h0_0000 : b,
				36'h9_0000_0000 + i);
		idle(3);
		for (int i = 0; i < 4; i++)
			rd(lin ? {b[17:2], b[1:0] + 2'(i)} : b ^ 18'(i),
				36'h9_0000_0000 + i);
	endtask : burst
	// ****
	// Main sequence
	// ****
	initial begin
		rst(1);
		ahb(0, SSC_CTRL_OFF, 0);
		chk("ctrl", 32'h0000_0001, r);
		chk("hresp", 0, hresp);
		ahb(0, SSC_STAT_OFF, 0);
		chk("stat", 32'h0000_0041, r & 32'h0000_0071);
		ahb(1, 8'h08, 32'hffff_ffff);
		ahb(0, 8'h08, 0);
		chk("unmapped", 0, r);
		wr(18'h0_0004, 4'h0, 36'h1_2345_6789);
		wr(18'h0_0004, 4'he, 36'h0_aaaa_aaaa);
		rd(18'h0_0004, 36'h0_2345_67aa);
		// Gated edge, three bad selects, advance with no live burst
		for (int k = 0; k < 5; k++) begin
			m.cmd(bad[k][4], bad[k][3:1], 0, bad[k][0], 4'h0, 18'h0_0004, 0);
			idle(3);
		end
		rd(18'h0_0004, 36'h0_2345_67aa);
		oen <= 1;
		rd(18'h0_0004, 0);
		oen <= 0;
		burst(18'h0_0005, 0);
		// Stalled drain: two words fill the buffer, the third is dropped
		ahb(1, SSC_CTRL_OFF, 32'h0000_0003);
		repeat (3) m.cmd(0, 3'h2, 1, 0, 4'hf, 18'h0_0004, 0);
		idle(3);
		chk("buf_ready", 0, rbr);
		ahb(0, SSC_STAT_OFF, 0);
		chk("stat_full", 32'h0000_0021, r & 32'h0000_0071);
		ahb(1, SSC_CTRL_OFF, 32'h0000_0001);
		idle(4);
		chk("buf_drained", 1, rbr);
		rst(0);
		ahb(0, SSC_STAT_OFF, 0);
		chk("mode", 0, r & 32'h0000_0001);
		burst(18'h0_0006, 1);
		final_report();
	end
endmodule : sync_sram_command_capture_tb_top
